// File: hdl/uart_regsel_pkg.sv
package uart_regsel_pkg;

    // ------------------------------------------------------------
    // register addresses (4-bit host address space)
    // ------------------------------------------------------------
    localparam logic [3:0] addr_holding        = 4'h0;
    localparam logic [3:0] addr_int_enables    = 4'h1;
    localparam logic [3:0] addr_ident_fifo     = 4'h2;
    localparam logic [3:0] addr_line_format    = 4'h3;
    localparam logic [3:0] addr_modem_control  = 4'h4;
    localparam logic [3:0] addr_line_status    = 4'h5;
    localparam logic [3:0] addr_modem_status   = 4'h6;
    localparam logic [3:0] addr_scratch        = 4'h7;
    localparam logic [3:0] addr_tx_fill        = 4'h8;
    localparam logic [3:0] addr_rx_fill        = 4'h9;
    localparam logic [3:0] addr_pin_direction  = 4'ha;
    localparam logic [3:0] addr_pin_states     = 4'hb;
    localparam logic [3:0] addr_pin_int_en     = 4'hc;
    localparam logic [3:0] addr_pin_control    = 4'he;
    localparam logic [3:0] addr_extra_features = 4'hf;
    // banked aliases
    localparam logic [3:0] addr_divisor_low    = 4'h0;
    localparam logic [3:0] addr_divisor_high   = 4'h1;
    localparam logic [3:0] addr_enhanced       = 4'h2;
    localparam logic [3:0] addr_resume_one     = 4'h4;
    localparam logic [3:0] addr_resume_two     = 4'h5;
    localparam logic [3:0] addr_pause_one      = 4'h6;
    localparam logic [3:0] addr_pause_two      = 4'h7;
    localparam logic [3:0] addr_trans_control  = 4'h6;
    localparam logic [3:0] addr_trigger_level  = 4'h7;

    // ------------------------------------------------------------
    // field positions and key values
    // ------------------------------------------------------------
    localparam int          lcr_latch_bit      = 7;
    localparam logic [7:0]  lcr_enhanced_key   = 8'hbf;
    localparam int          efr_enhanced_bit   = 4;
    localparam int          mcr_bank_bit       = 2;
    localparam int          mcr_prescale_bit   = 7;
    // modem control bits 7:5 and interrupt enable bits 7:4 are enhanced
    localparam logic [7:0]  mcr_enhanced_mask  = 8'he0;
    localparam logic [7:0]  ier_enhanced_mask  = 8'hf0;
    localparam logic [7:0]  reg_reset_value    = 8'h00;
    localparam logic [7:0]  read_zero          = 8'h00;
    localparam int          reg_count          = 21;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [3:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [7:0] rx_char;
        logic [7:0] ident;
        logic [7:0] line_stat;
        logic [7:0] modem_stat;
        logic [7:0] tx_fill;
        logic [7:0] rx_fill;
        logic [7:0] pin_levels;
    } core_status_t;

    typedef enum {
        bank_general,
        bank_divisor,
        bank_enhanced
    } bank_t;

endpackage : uart_regsel_pkg

// File: hdl/uart_reg_cell.sv
`timescale 1ns/1ps
// one host-writable byte with a per-bit write-protect mask
module uart_reg_cell #(
    parameter int         width = 8,
    parameter logic [7:0] reset_value = 8'h00
) (
    // clocking
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             clock_en,
    // write port
    input  wire logic             wr_en,
    input  wire logic [width-1:0] wr_data,
    input  wire logic [width-1:0] wr_keep,
    // contents
    output logic      [width-1:0] value
);

    logic [width-1:0] value_next;

    // protected bits keep their old value
    assign value_next = (wr_data & ~wr_keep) | (value & wr_keep);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            value <= reset_value[width-1:0];
        end else if (clock_en && wr_en) begin
            value <= value_next;
        end
    end

endmodule : uart_reg_cell

// File: hdl/uart_bank_decode.sv
`timescale 1ns/1ps
// bank selection from line format, enhanced features and modem control
module uart_bank_decode (
    // steering registers
    input  wire logic [7:0] line_format,
    input  wire logic [7:0] enhanced,
    input  wire logic [7:0] modem_control,
    // decoded conditions
    output uart_regsel_pkg::bank_t bank,
    output logic            enh_enabled,
    output logic            trig_bank
);

    // ------------------------------------------------------------
    // bank conditions
    // ------------------------------------------------------------
    // exact key match wins over the latch bit, since the key has bit 7 set too
    wire key_match = (line_format == uart_regsel_pkg::lcr_enhanced_key);
    wire latch_on  = line_format[uart_regsel_pkg::lcr_latch_bit];

    assign bank = key_match ? uart_regsel_pkg::bank_enhanced :
                  latch_on  ? uart_regsel_pkg::bank_divisor  :
                              uart_regsel_pkg::bank_general;
    assign enh_enabled = enhanced[uart_regsel_pkg::efr_enhanced_bit];
    assign trig_bank   = enh_enabled &&
                         modem_control[uart_regsel_pkg::mcr_bank_bit];

endmodule : uart_bank_decode

// File: hdl/uart_banked_register_select.sv
`timescale 1ns/1ps
module uart_banked_register_select (
    // clock and reset
    input  wire logic                         clock,
    input  wire logic                         reset_n,
    input  wire logic                         clock_en,
    // host access port (from serial bus slave, same clock)
    input  wire uart_regsel_pkg::host_req_t   host_req,
    output logic [7:0]                        host_rdata,
    output logic                              host_rvalid,
    // status from uart core (same clock)
    input  wire uart_regsel_pkg::core_status_t core_status,
    // strobes toward uart core
    output logic                              rx_pop,
    output logic                              tx_push,
    output logic [7:0]                        tx_char,
    output logic                              fifo_ctl_wr,
    output logic [7:0]                        fifo_ctl_value,
    output logic                              ident_read,
    // configuration toward uart core
    output logic [7:0]                        int_enables,
    output logic [7:0]                        line_format_control,
    output logic [7:0]                        modem_pin_control,
    output logic [7:0]                        scratch_byte,
    output logic [15:0]                       divisor,
    output logic [7:0]                        enhanced_features,
    output logic [7:0]                        resume_char_one,
    output logic [7:0]                        resume_char_two,
    output logic [7:0]                        pause_char_one,
    output logic [7:0]                        pause_char_two,
    output logic [7:0]                        transmission_control,
    output logic [7:0]                        trigger_level,
    output logic [7:0]                        pin_direction,
    output logic [7:0]                        pin_interrupt_enables,
    output logic [7:0]                        pin_control,
    output logic [7:0]                        extra_features
);

    // ------------------------------------------------------------
    // register index map inside the storage array
    // ------------------------------------------------------------
    localparam int ix_ier  = 0;
    localparam int ix_lcr  = 1;
    localparam int ix_mcr  = 2;
    localparam int ix_spr  = 3;
    localparam int ix_dll  = 4;
    localparam int ix_dlh  = 5;
    localparam int ix_efr  = 6;
    localparam int ix_xn1  = 7;
    localparam int ix_xn2  = 8;
    localparam int ix_xf1  = 9;
    localparam int ix_xf2  = 10;
    localparam int ix_tcr  = 11;
    localparam int ix_tlr  = 12;
    localparam int ix_dir  = 13;
    localparam int ix_pie  = 14;
    localparam int ix_ctl  = 15;
    localparam int ix_efc  = 16;
    localparam int n_regs  = 17;

    logic [7:0] regs      [n_regs];
    logic [7:0] keep_mask [n_regs];
    logic       wr_hit    [n_regs];

    uart_regsel_pkg::bank_t bank;
    logic       enh_enabled;
    logic       trig_bank;

    // ------------------------------------------------------------
    // bank decode
    // ------------------------------------------------------------
    uart_bank_decode u_bank (
        .line_format   (regs[ix_lcr]),
        .enhanced      (regs[ix_efr]),
        .modem_control (regs[ix_mcr]),
        .bank          (bank),
        .enh_enabled   (enh_enabled),
        .trig_bank     (trig_bank)
    );

    // ------------------------------------------------------------
    // access qualification
    // ------------------------------------------------------------
    wire        acc      = host_req.valid && clock_en;
    wire        is_wr    = acc && host_req.write;
    wire        is_rd    = acc && !host_req.write;
    wire [3:0]  a        = host_req.addr;
    wire        b_gen    = (bank == uart_regsel_pkg::bank_general);
    wire        b_div    = (bank == uart_regsel_pkg::bank_divisor);
    wire        b_enh    = (bank == uart_regsel_pkg::bank_enhanced);
    // high addresses are outside the banked window, so they stay open in every bank
    wire        hi_addr  = a[3];
    // trigger pair overlays modem status and scratch in the general bank
    wire        trig_hit = b_gen && trig_bank &&
                           (a == uart_regsel_pkg::addr_trans_control ||
                            a == uart_regsel_pkg::addr_trigger_level);

    // per-register address hits, writable registers only
    wire h_ier = b_gen && a == uart_regsel_pkg::addr_int_enables;
    wire h_lcr = !hi_addr && a == uart_regsel_pkg::addr_line_format;
    wire h_mcr = b_gen && a == uart_regsel_pkg::addr_modem_control;
    wire h_spr = b_gen && !trig_hit && a == uart_regsel_pkg::addr_scratch;
    wire h_dll = b_div && a == uart_regsel_pkg::addr_divisor_low;
    wire h_dlh = b_div && a == uart_regsel_pkg::addr_divisor_high;
    wire h_efr = b_enh && a == uart_regsel_pkg::addr_enhanced;
    wire h_xn1 = b_enh && a == uart_regsel_pkg::addr_resume_one;
    wire h_xn2 = b_enh && a == uart_regsel_pkg::addr_resume_two;
    wire h_xf1 = b_enh && a == uart_regsel_pkg::addr_pause_one;
    wire h_xf2 = b_enh && a == uart_regsel_pkg::addr_pause_two;
    wire h_tcr = trig_hit && a == uart_regsel_pkg::addr_trans_control;
    wire h_tlr = trig_hit && a == uart_regsel_pkg::addr_trigger_level;
    wire h_dir = a == uart_regsel_pkg::addr_pin_direction;
    wire h_pie = a == uart_regsel_pkg::addr_pin_int_en;
    wire h_ctl = a == uart_regsel_pkg::addr_pin_control;
    wire h_efc = a == uart_regsel_pkg::addr_extra_features;

    // shared-address strobes, general bank only
    wire h_hold  = b_gen && a == uart_regsel_pkg::addr_holding;
    wire h_ident = b_gen && a == uart_regsel_pkg::addr_ident_fifo;

    // enhanced-tagged bits frozen while enhanced functions are off
    wire [7:0] enh_keep_mcr = enh_enabled ? 8'h00 : uart_regsel_pkg::mcr_enhanced_mask;
    wire [7:0] enh_keep_ier = enh_enabled ? 8'h00 : uart_regsel_pkg::ier_enhanced_mask;

    // ------------------------------------------------------------
    // write enables and protect masks per array entry
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < n_regs; i++) begin
            keep_mask[i] = 8'h00;
        end
        keep_mask[ix_ier] = enh_keep_ier;
        keep_mask[ix_mcr] = enh_keep_mcr;
        wr_hit[ix_ier] = is_wr && h_ier;
        wr_hit[ix_lcr] = is_wr && h_lcr;
        wr_hit[ix_mcr] = is_wr && h_mcr;
        wr_hit[ix_spr] = is_wr && h_spr;
        wr_hit[ix_dll] = is_wr && h_dll;
        wr_hit[ix_dlh] = is_wr && h_dlh;
        wr_hit[ix_efr] = is_wr && h_efr;
        wr_hit[ix_xn1] = is_wr && h_xn1;
        wr_hit[ix_xn2] = is_wr && h_xn2;
        wr_hit[ix_xf1] = is_wr && h_xf1;
        wr_hit[ix_xf2] = is_wr && h_xf2;
        wr_hit[ix_tcr] = is_wr && h_tcr;
        wr_hit[ix_tlr] = is_wr && h_tlr;
        wr_hit[ix_dir] = is_wr && h_dir;
        wr_hit[ix_pie] = is_wr && h_pie;
        wr_hit[ix_ctl] = is_wr && h_ctl;
        wr_hit[ix_efc] = is_wr && h_efc;
    end

    // ------------------------------------------------------------
    // storage: one cell per writable register
    // ------------------------------------------------------------
    // read-only status (line, modem, fills, pin states) has no cell at all,
    // so a write to those addresses simply finds nothing to change
    for (genvar g = 0; g < n_regs; g++) begin : g_cell
        uart_reg_cell #(
            .width       (8),
            .reset_value (uart_regsel_pkg::reg_reset_value)
        ) u_cell (
            .clock    (clock),
            .reset_n  (reset_n),
            .clock_en (clock_en),
            .wr_en    (wr_hit[g]),
            .wr_data  (host_req.wdata),
            .wr_keep  (keep_mask[g]),
            .value    (regs[g])
        );
    end

    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = uart_regsel_pkg::read_zero;
        if (h_hold)                 rd_mux = core_status.rx_char;
        else if (h_ident)           rd_mux = core_status.ident;
        else if (h_ier)             rd_mux = regs[ix_ier];
        else if (h_lcr)             rd_mux = regs[ix_lcr];
        else if (h_mcr)             rd_mux = regs[ix_mcr];
        else if (b_gen && a == uart_regsel_pkg::addr_line_status)
                                    rd_mux = core_status.line_stat;
        else if (h_tcr)             rd_mux = regs[ix_tcr];
        else if (h_tlr)             rd_mux = regs[ix_tlr];
        else if (b_gen && a == uart_regsel_pkg::addr_modem_status)
                                    rd_mux = core_status.modem_stat;
        else if (h_spr)             rd_mux = regs[ix_spr];
        else if (h_dll)             rd_mux = regs[ix_dll];
        else if (h_dlh)             rd_mux = regs[ix_dlh];
        else if (h_efr)             rd_mux = regs[ix_efr];
        else if (h_xn1)             rd_mux = regs[ix_xn1];
        else if (h_xn2)             rd_mux = regs[ix_xn2];
        else if (h_xf1)             rd_mux = regs[ix_xf1];
        else if (h_xf2)             rd_mux = regs[ix_xf2];
        else if (a == uart_regsel_pkg::addr_tx_fill)
                                    rd_mux = core_status.tx_fill;
        else if (a == uart_regsel_pkg::addr_rx_fill)
                                    rd_mux = core_status.rx_fill;
        else if (h_dir)             rd_mux = regs[ix_dir];
        else if (a == uart_regsel_pkg::addr_pin_states)
                                    rd_mux = core_status.pin_levels;
        else if (h_pie)             rd_mux = regs[ix_pie];
        else if (h_ctl)             rd_mux = regs[ix_ctl];
        else if (h_efc)             rd_mux = regs[ix_efc];
    end

    // ------------------------------------------------------------
    // registered answers and core strobes
    // ------------------------------------------------------------
    // strobes last until the next clock_en edge; the core owns fifo timing after a reset strobe,
    // the host is expected to leave two crystal periods before touching data
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            host_rdata     <= 8'h00;
            host_rvalid    <= 1'b0;
            rx_pop         <= 1'b0;
            tx_push        <= 1'b0;
            tx_char        <= 8'h00;
            fifo_ctl_wr    <= 1'b0;
            fifo_ctl_value <= 8'h00;
            ident_read     <= 1'b0;
        end else if (clock_en) begin
            host_rvalid <= is_rd;
            host_rdata  <= is_rd ? rd_mux : host_rdata;
            rx_pop      <= is_rd && h_hold;
            tx_push     <= is_wr && h_hold;
            tx_char     <= (is_wr && h_hold) ? host_req.wdata : tx_char;
            fifo_ctl_wr <= is_wr && h_ident;
            fifo_ctl_value <= (is_wr && h_ident) ? host_req.wdata : fifo_ctl_value;
            ident_read  <= is_rd && h_ident;
        end
    end

    // ------------------------------------------------------------
    // configuration outputs straight from the cells
    // ------------------------------------------------------------
    assign int_enables           = regs[ix_ier];
    assign line_format_control   = regs[ix_lcr];
    assign modem_pin_control     = regs[ix_mcr];
    assign scratch_byte          = regs[ix_spr];
    assign divisor               = {regs[ix_dlh], regs[ix_dll]};
    assign enhanced_features     = regs[ix_efr];
    assign resume_char_one       = regs[ix_xn1];
    assign resume_char_two       = regs[ix_xn2];
    assign pause_char_one        = regs[ix_xf1];
    assign pause_char_two        = regs[ix_xf2];
    assign transmission_control  = regs[ix_tcr];
    assign trigger_level         = regs[ix_tlr];
    assign pin_direction         = regs[ix_dir];
    assign pin_interrupt_enables = regs[ix_pie];
    assign pin_control           = regs[ix_ctl];
    assign extra_features        = regs[ix_efc];

endmodule : uart_banked_register_select

// File: test/uart_regsel_props.sv
`timescale 1ns/1ps
// watches the register block from its ports only
module uart_regsel_props (
    // clocking and strobes (ports grouped to keep the checker short)
    input wire logic clock, reset_n, clock_en, host_rvalid, rx_pop, tx_push, fifo_ctl_wr,
    input wire logic ident_read,
    // host side and core side
    input wire uart_regsel_pkg::host_req_t    host_req,
    input wire uart_regsel_pkg::core_status_t core_status,
    // answers and configuration
    input wire logic [7:0]  host_rdata, tx_char, fifo_ctl_value, line_format_control,
    input wire logic [7:0]  modem_pin_control, enhanced_features,
    input wire logic [15:0] divisor
);
    // request decode; the general bank holds whenever the latch bit is clear
    wire logic take = host_req.valid && clock_en;
    wire logic gen  = !line_format_control[7];
    wire logic rd0  = take && !host_req.write;
    wire logic wr0  = take && host_req.write;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_read_answer: assert property (rd0 |=> host_rvalid)
        else $error("read was not answered next cycle");
    a_rx_pop_read: assert property (rd0 && gen && host_req.addr == 4'h0 |=>
        rx_pop && host_rdata == $past(core_status.rx_char)) else $error("receive read wrong");
    a_tx_push_write: assert property (wr0 && gen && host_req.addr == 4'h0 |=>
        tx_push && tx_char == $past(host_req.wdata)) else $error("transmit write wrong");
    a_fifo_ctl_write: assert property (wr0 && gen && host_req.addr == 4'h2 |=>
        fifo_ctl_wr && fifo_ctl_value == $past(host_req.wdata)) else $error("fifo write wrong");
    a_ident_read: assert property (rd0 && gen && host_req.addr == 4'h2 |=>
        ident_read && host_rdata == $past(core_status.ident)) else $error("ident read wrong");
    a_line_stat_ro: assert property (rd0 && gen && host_req.addr == 4'h5 |=>
        host_rdata == $past(core_status.line_stat)) else $error("line status read wrong");
    a_divisor_locked: assert property (gen |=> $stable(divisor))
        else $error("divisor changed outside its bank");
    a_key_unlock: assert property (wr0 && line_format_control == 8'hbf &&
        host_req.addr == 4'h2 |=> enhanced_features == $past(host_req.wdata))
        else $error("enhanced register not written under key");
    a_prescale_kept: assert property (!enhanced_features[4] |=>
        modem_pin_control[7] == $past(modem_pin_control[7])) else $error("prescaler moved");
    a_reserved_zero: assert property (rd0 && host_req.addr == 4'hd |=>
        host_rdata == 8'h00) else $error("reserved address read nonzero");
    // main scenarios reached
    cover property (rx_pop);
    cover property (fifo_ctl_wr);
    cover property (wr0 && line_format_control == 8'hbf);
endmodule : uart_regsel_props

bind uart_banked_register_select uart_regsel_props u_uart_regsel_props (
    .clock(clock), .reset_n(reset_n), .clock_en(clock_en), .host_rvalid(host_rvalid),
    .rx_pop(rx_pop), .tx_push(tx_push), .fifo_ctl_wr(fifo_ctl_wr), .ident_read(ident_read),
    .host_req(host_req), .core_status(core_status), .host_rdata(host_rdata),
    .tx_char(tx_char), .fifo_ctl_value(fifo_ctl_value), .divisor(divisor),
    .line_format_control(line_format_control), .modem_pin_control(modem_pin_control),
    .enhanced_features(enhanced_features));

// File: test/uart_core_model.sv
`timescale 1ns/1ps
// stand-in for the uart core: fixed status levels, receive data advances per pop
module uart_core_model (
    // clocking
    input  wire logic                      clock,
    input  wire logic                      reset_n,
    // strobe from the register block
    input  wire logic                      rx_pop,
    // status levels
    output uart_regsel_pkg::core_status_t  core_status
);
    logic [7:0] pops_reg;
    // the oldest character changes only when popped, so a stray pop shows up
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) pops_reg <= 8'h00;
        else if (rx_pop) pops_reg <= pops_reg + 8'h01;
    end
    assign core_status = {8'h41 + pops_reg, 8'hc1, 8'h60, 8'hb0, 8'h40, 8'h03, 8'h5a};
endmodule : uart_core_model

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic                          clock = 1'b0;
    logic                          reset_n = 1'b0;
    uart_regsel_pkg::host_req_t    host_req = '0;
    uart_regsel_pkg::core_status_t core_status;
    logic                          clock_en = 1'b1;
    logic                          rx_pop, host_rvalid;
    logic [7:0]                    cfg [11];
    logic [7:0]                    host_rdata;
    logic [15:0]                   divisor;
    int                            bad_count = 0;
    int                            samples_checked = 0;
    int                            cycles = 0;
    // each entry is {write flag, address, data written or value expected}
    logic [15:0] ops [] = '{16'h0300, 16'h0041, 16'h0042, 16'h105a, 16'h02c1,
        16'h1207, 16'h0043,
        16'h15ff, 16'h0560, 16'h16ff, 16'h06b0, 16'h18ff, 16'h0840,
        16'h19ff, 16'h0903, 16'h1bff, 16'h0b5a,
        16'h1703, 16'h0703, 16'h1a03, 16'h0a03, 16'h1c03, 16'h0c03,
        16'h1e03, 16'h0e03, 16'h1f03, 16'h0f03,
        16'h1380, 16'h1034, 16'h1112, 16'h0034, 16'h0112, 16'h0700,
        16'h1303, 16'h0044, 16'h14e4, 16'h0404, 16'h11ff, 16'h010f,
        16'h13bf, 16'h1210, 16'h1411, 16'h0411, 16'h0210, 16'h1303,
        16'h1666, 16'h0666, 16'h1777, 16'h0777,
        16'h14e0, 16'h04e0, 16'h06b0, 16'h0d00};

    uart_banked_register_select u_uart_banked_register_select (
        .clock(clock), .reset_n(reset_n), .clock_en(clock_en), .host_req(host_req),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .core_status(core_status),
        .rx_pop(rx_pop), .tx_push(), .tx_char(), .fifo_ctl_wr(), .fifo_ctl_value(),
        .ident_read(), .int_enables(cfg[0]), .line_format_control(cfg[1]),
        .modem_pin_control(cfg[2]), .scratch_byte(cfg[3]), .divisor(divisor),
        .enhanced_features(cfg[4]), .resume_char_one(cfg[5]), .resume_char_two(),
        .pause_char_one(), .pause_char_two(), .transmission_control(cfg[6]),
        .trigger_level(cfg[7]), .pin_direction(cfg[8]), .pin_interrupt_enables(cfg[9]),
        .pin_control(cfg[10]), .extra_features());
    uart_core_model u_uart_core_model (
        .clock(clock), .reset_n(reset_n), .rx_pop(rx_pop), .core_status(core_status));

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one request cycle, then one idle cycle so valid is never set twice in one step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host_req <= '{valid: 1'b1, write: 1'b1, addr: a, wdata: d};
        @(negedge clock);
        host_req.valid <= 1'b0;
        @(negedge clock);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        host_req <= '{valid: 1'b1, write: 1'b0, addr: a, wdata: 8'h00};
        @(negedge clock);
        host_req.valid <= 1'b0;
        check("rvalid", 8'h01, {7'h00, host_rvalid});
        check($sformatf("read %h", a), exp, host_rdata);
        @(negedge clock);
    endtask : rd

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test

    initial begin
        forever #10 clock = ~clock;
    end

    // hang guard: the whole walk needs about a hundred cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            stop_test();
        end
    end

    initial begin
        repeat (12) @(negedge clock);
        reset_n = 1'b1;
        @(negedge clock);
        foreach (ops[i]) begin
            if (ops[i][12]) wr(ops[i][11:8], ops[i][7:0]);
            else rd(ops[i][11:8], ops[i][7:0]);
        end
        $display("test register walk done");
        check("divisor low", 8'h34, divisor[7:0]);
        check("divisor high", 8'h12, divisor[15:8]);
        $display("test divisor bytes done");
        // configuration outputs must mirror what the bus last wrote or read back
        check("int enables", 8'h0f, cfg[0]);
        check("line format", 8'h03, cfg[1]);
        check("modem control", 8'he0, cfg[2]);
        check("scratch", 8'h03, cfg[3]);
        check("enhanced", 8'h10, cfg[4]);
        check("resume one", 8'h11, cfg[5]);
        check("trans control", 8'h66, cfg[6]);
        check("trigger level", 8'h77, cfg[7]);
        check("pin direction", 8'h03, cfg[8]);
        check("pin int enables", 8'h03, cfg[9]);
        check("pin control", 8'h03, cfg[10]);
        $display("test config outputs done");
        // a write while the enable is low must leave the scratch byte alone
        clock_en = 1'b0;
        wr(4'h7, 8'h99);
        clock_en = 1'b1;
        rd(4'h7, 8'h03);
        $display("test clock enable freeze done");
        stop_test();
    end
endmodule : testbench
